/* File: verification/pc_card_socket_signalling_tb.sv */
// Self-checking bench for the two-socket card signalling top.
// Assumes card models on both sockets; expectations queued by the driver.
`timescale 1ns/100ps
`default_nettype none
module pc_card_socket_signalling_tb
  import pcss_pkg::*;
;
  typedef struct {pcss_op_t op; logic rd, err, rg, chk_rd; logic [1:0] ce; logic [25:0] a; logic [15:0] wd; int t, w;} pcss_note_t;
  logic core_clk = 1'b0, rst_b = 1'b0;
  pcss_mode_t [1:0] mode;
  pcss_op_t [1:0] req_op;
  logic [1:0] card_8bit, power_on, if_enable, card_reset_req, req_valid, req_attr, req_word;
  logic [1:0][ADDR_W-1:0] req_addr, card_addr;
  logic [1:0][DATA_W-1:0] req_wdata, rsp_rdata, card_data_i, card_data_o;
  logic [1:0] req_ready, rsp_valid, rsp_err, card_present, write_protect, card_ready, card_irq, ata_mode;
  logic [1:0] card_data_oe, reg_b, oe_b, we_b, iord_b, iowr_b, wp_iois16_b, rdy_ireq_b, wait_b, inpack_b;
  logic [1:0] card_rst_o, card_rst_oe, present, wp_lvl, rdy_lvl;
  logic [1:0][1:0] ce_b, cd_b;
  logic [1:0][3:0] wait_cyc;
  logic [31:0] lfsr_st = 32'hb8d8;
  int cyc = 0, fail_count = 0, comparisons = 0;
  pcss_note_t q[2][$];
  initial forever #20 core_clk = ~core_clk;
  pcss_top DUT (.core_clk(core_clk), .rst_b(rst_b), .mode(mode), .card_8bit(card_8bit), .power_on(power_on),
    .if_enable(if_enable), .card_reset_req(card_reset_req), .req_valid(req_valid), .req_op(req_op),
    .req_attr(req_attr), .req_word(req_word), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err), .card_present(card_present),
    .write_protect(write_protect), .card_ready(card_ready), .card_irq(card_irq), .ata_mode(ata_mode),
    .card_addr(card_addr), .card_data_i(card_data_i), .card_data_o(card_data_o), .card_data_oe(card_data_oe),
    .reg_b(reg_b), .oe_b(oe_b), .we_b(we_b), .iord_b(iord_b), .iowr_b(iowr_b), .ce_b(ce_b),
    .wp_iois16_b(wp_iois16_b), .rdy_ireq_b(rdy_ireq_b), .wait_b(wait_b), .inpack_b(inpack_b), .cd_b(cd_b),
    .card_rst_o(card_rst_o), .card_rst_oe(card_rst_oe));
  // ==========================================================
  // Reporting
  function automatic logic [31:0] lfsr();
    lfsr_st = {lfsr_st[30:0], lfsr_st[31] ^ lfsr_st[21] ^ lfsr_st[1] ^ lfsr_st[0]};
    return lfsr_st;
  endfunction
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  // ==========================================================
  // Card models and response watchers
  for (genvar s = 0; s < 2; s++) begin : g_sock
    int sn = 0;
    pcss_op_t sop;
    logic srg, soe;
    logic [1:0] sce;
    logic [25:0] sa;
    logic [15:0] swd;
    pcss_note_t n;
    pcss_card_model card (.core_clk(core_clk), .present(present[s]), .wp_level(wp_lvl[s]), .rdy_level(rdy_lvl[s]),
      .wait_cyc(wait_cyc[s]), .card_addr(card_addr[s]), .oe_b(oe_b[s]), .we_b(we_b[s]), .iord_b(iord_b[s]),
      .iowr_b(iowr_b[s]), .card_data_i(card_data_i[s]), .wait_b(wait_b[s]), .inpack_b(inpack_b[s]),
      .cd_b(cd_b[s]), .wp_iois16_b(wp_iois16_b[s]), .rdy_ireq_b(rdy_ireq_b[s]));
    always @(posedge core_clk) begin
      if (rst_b) begin
        if ($countones({oe_b[s], we_b[s], iord_b[s], iowr_b[s]}) < 3) check_val(0, 1, "strobes overlap");
        if ($countones({oe_b[s], we_b[s], iord_b[s], iowr_b[s]}) == 3) begin
          sn++;
          sop = !oe_b[s] ? PCSS_OP_MEM_RD : !we_b[s] ? PCSS_OP_MEM_WR : !iord_b[s] ? PCSS_OP_IO_RD : PCSS_OP_IO_WR;
          srg = reg_b[s];
          sce = ce_b[s];
          sa = card_addr[s];
          swd = card_data_o[s];
          soe = card_data_oe[s];
        end
        if (rsp_valid[s] === 1'b1 && q[s].size() == 0) check_val(0, 1, "unexpected response");
        else if (rsp_valid[s] === 1'b1) begin
          n = q[s].pop_front();
          check_val(rsp_err[s], n.err, "error flag");
          if (n.err) check_val(sn, 0, "strobe on absent card");
          else begin
            check_val(sop, n.op, "strobe kind");
            check_val(srg, n.rg, "space select");
            check_val(sce, n.ce, "card enables");
            check_val(sa, n.a, "address");
            check_val(soe, !n.rd, "data drive");
            if (!n.rd) check_val(swd, n.wd, "write data");
            if (n.chk_rd) check_val(rsp_rdata[s], n.a[15:0] ^ 16'h3c5a, "read data");
            check_val(n.w == 0 ? (cyc - n.t inside {[5:6]}) : (cyc - n.t >= n.w + 4), 1, "latency");
          end
          sn = 0;
        end
      end
    end
  end
  // ==========================================================
  // Drivers
  task automatic access(input int s, input pcss_op_t op, input logic attr, input logic word, input logic a0);
    pcss_note_t n;
    logic narrow;
    logic [31:0] r;
    int k;
    repeat (2) @(posedge core_clk);
    r = lfsr();
    n.op = op;
    n.rd = op inside {PCSS_OP_MEM_RD, PCSS_OP_IO_RD};
    n.err = !present[s];
    n.a = {r[25:1], a0};
    n.wd = lfsr_st[15:0] ^ r[31:16];
    n.rg = mode[s] == PCSS_IF_ATA ? 1'b1 : mode[s] == PCSS_IF_IO ? 1'b0 : !attr;
    narrow = card_8bit[s] || !word || (mode[s] != PCSS_IF_MEM && wp_lvl[s]);
    n.ce = !narrow ? 2'b00 : (card_8bit[s] || !a0) ? 2'b10 : 2'b01;
    n.chk_rd = n.rd && !narrow;
    n.w = wait_cyc[s];
    req_valid[s] <= 1'b1;
    req_op[s] <= op;
    req_attr[s] <= attr;
    req_word[s] <= word;
    req_addr[s] <= n.a;
    req_wdata[s] <= n.wd;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (req_ready[s] !== 1'b1 && k < 50);
    if (req_ready[s] !== 1'b1) check_val(0, 1, "request not taken");
    n.t = cyc;
    q[s].push_back(n);
    req_valid[s] <= 1'b0;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (rsp_valid[s] !== 1'b1 && k < 60);
    if (rsp_valid[s] !== 1'b1) check_val(0, 1, "no response");
  endtask
  // Order: present, write protect, ready, irq, ata, reset enable, reset level
  task automatic status(input int s, input logic [6:0] exp, input string msg);
    repeat (3) @(posedge core_clk);
    check_val({card_present[s], write_protect[s], card_ready[s], card_irq[s], ata_mode[s], card_rst_oe[s],
      card_rst_o[s]}, exp, msg);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    mode[0] = PCSS_IF_MEM;
    mode[1] = PCSS_IF_MEM;
    req_op[0] = PCSS_OP_MEM_RD;
    req_op[1] = PCSS_OP_MEM_RD;
    {card_8bit, card_reset_req, req_valid, req_attr, req_word, req_addr, req_wdata} = '0;
    {power_on, if_enable, present, rdy_lvl} = 8'hff;
    wp_lvl = 2'b00;
    wait_cyc = '0;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    status(0, 7'b1010010, "idle status");
    wp_lvl[0] <= 1'b1;
    rdy_lvl[0] <= 1'b0;
    card_reset_req[0] <= 1'b1;
    status(0, 7'b1100011, "protect busy reset");
    power_on[0] <= 1'b0;
    status(0, 7'b1100001, "unpowered reset pin");
    {power_on[0], if_enable[0], wp_lvl[0], rdy_lvl[0], card_reset_req[0]} <= 5'b10010;
    status(0, 7'b1010000, "disabled reset pin");
    if_enable[0] <= 1'b1;
    $display("test status done");
    for (int i = 0; i < 8; i++) access(0, i[0] ? PCSS_OP_MEM_WR : PCSS_OP_MEM_RD, i[1], i[2], lfsr_st[3]);
    card_8bit[0] <= 1'b1;
    for (int i = 0; i < 4; i++) access(0, i[0] ? PCSS_OP_MEM_WR : PCSS_OP_MEM_RD, 1'b0, 1'b1, i[1]);
    card_8bit[0] <= 1'b0;
    $display("test memory done");
    mode[0] <= PCSS_IF_IO;
    for (int i = 0; i < 8; i++) begin
      wp_lvl[0] <= i[1];
      access(0, i[0] ? PCSS_OP_IO_WR : PCSS_OP_IO_RD, 1'b1, 1'b1, i[2]);
    end
    wp_lvl[0] <= 1'b0;
    rdy_lvl[0] <= 1'b0;
    status(0, 7'b1001010, "io interrupt");
    rdy_lvl[0] <= 1'b1;
    wait_cyc[0] <= 4'h6;
    access(0, PCSS_OP_IO_RD, 1'b0, 1'b1, 1'b0);
    access(0, PCSS_OP_IO_WR, 1'b0, 1'b1, 1'b0);
    wait_cyc[0] <= 4'h0;
    $display("test io and wait done");
    mode[0] <= PCSS_IF_ATA;
    access(0, PCSS_OP_IO_RD, 1'b0, 1'b1, 1'b0);
    access(0, PCSS_OP_IO_WR, 1'b1, 1'b1, 1'b1);
    check_val(ata_mode[0], 1'b1, "ata flag");
    $display("test ata done");
    present[1] <= 1'b0;
    status(1, 7'b0010000, "socket b absent");
    access(1, PCSS_OP_MEM_RD, 1'b0, 1'b1, 1'b0);
    access(1, PCSS_OP_MEM_WR, 1'b0, 1'b1, 1'b0);
    present[1] <= 1'b1;
    mode[0] <= PCSS_IF_MEM;
    mode[1] <= PCSS_IF_IO;
    fork
      access(0, PCSS_OP_MEM_WR, 1'b1, 1'b1, 1'b0);
      access(1, PCSS_OP_IO_RD, 1'b0, 1'b1, 1'b0);
    join
    $display("test sockets done");
    repeat (4) @(posedge core_clk);
    check_val(q[0].size() + q[1].size(), 0, "responses missing");
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* File: verification/pcss_card_model.sv */
// Behavioural model of one inserted card for the socket signalling block.
// Assumes pins sampled on core_clk; the bench sets presence and pin levels.
`timescale 1ns/100ps
`default_nettype none
module pcss_card_model
  import pcss_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              present,
  input  wire logic              wp_level,
  input  wire logic              rdy_level,
  input  wire logic [3:0]        wait_cyc,
  input  wire logic [ADDR_W-1:0] card_addr,
  input  wire logic              oe_b,
  input  wire logic              we_b,
  input  wire logic              iord_b,
  input  wire logic              iowr_b,
  output logic [DATA_W-1:0]      card_data_i,
  output logic                   wait_b,
  output logic                   inpack_b,
  output logic [1:0]             cd_b,
  output logic                   wp_iois16_b,
  output logic                   rdy_ireq_b
);
  logic [3:0]        wait_left = 4'h0;
  logic [DATA_W-1:0] last      = 16'h0;
  logic              act_prev  = 1'b0;
  wire logic         rd        = !oe_b || !iord_b;
  wire logic         act       = rd || !we_b || !iowr_b;
  logic              inpack_t  = 1'b1;
  assign inpack_b = inpack_t;
  // ==========================================================
  // Pins
  assign cd_b        = present ? 2'b00 : 2'b11;
  assign wp_iois16_b = wp_level;
  assign rdy_ireq_b  = rdy_level;
  assign wait_b      = wait_left == 4'h0;
  // Released bus shows the inverse of the last value so a stale sample is seen
  assign card_data_i = rd ? (card_addr[15:0] ^ 16'h3c5a) : ~last;
  always @(posedge core_clk) begin
    inpack_t <= ~inpack_t;
    act_prev <= act;
    if (rd) last <= card_addr[15:0] ^ 16'h3c5a;
    if (act && !act_prev) wait_left <= wait_cyc;
    else if (wait_left != 4'h0) wait_left <= wait_left - 4'h1;
  end
endmodule
`default_nettype wire

/* File: verilog/pcss_in_sync.sv */
// Input conditioning for one socket's status pins.
// Inputs are synchronous to core_clk; this just registers and decodes them.
`timescale 1ns/100ps
`default_nettype none
module pcss_in_sync
  import pcss_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire pcss_mode_t mode,
  input  wire logic [1:0] cd_b,
  input  wire logic       wp_iois16_b,
  input  wire logic       rdy_ireq_b,
  output logic            card_present,
  output logic            write_protect,
  output logic            io_is16,
  output logic            card_ready,
  output logic            card_irq
);
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      card_present  <= 1'b0;
      write_protect <= 1'b0;
      io_is16       <= 1'b0;
      card_ready    <= 1'b0;
      card_irq      <= 1'b0;
    end else begin
      card_present  <= pcss_card_seated(cd_b);
      write_protect <= (mode == PCSS_IF_MEM) && wp_iois16_b;
      io_is16       <= (mode != PCSS_IF_MEM) && !wp_iois16_b;
      card_ready    <= (mode == PCSS_IF_MEM) && rdy_ireq_b;
      card_irq      <= (mode == PCSS_IF_IO) && !rdy_ireq_b;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/pcss_pkg.sv */
// Shared constants and types for the PC Card socket signalling block.
// Assumes a single 25 MHz core clock and synchronous active-low reset.
package pcss_pkg;
  localparam int ADDR_W = 26;
  localparam int DATA_W = 16;
  localparam int NUM_SOCK = 2;
  // Core clock period in ns
  localparam int CLK_PERIOD_NS = 40;
  // Least strobe width in ns and its cycle count (rounded up)
  localparam int STROBE_MIN_NS = 120;
  localparam int STROBE_CYC = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
  // Reset values of the socket pins
  localparam logic RESET_CARD_RST = 1'b0;
  localparam logic STROBE_IDLE = 1'b1;

  typedef enum logic [1:0] {
    PCSS_IF_MEM,
    PCSS_IF_IO,
    PCSS_IF_ATA
  } pcss_mode_t;

  typedef enum logic [1:0] {
    PCSS_OP_MEM_RD,
    PCSS_OP_MEM_WR,
    PCSS_OP_IO_RD,
    PCSS_OP_IO_WR
  } pcss_op_t;

  // Card seated only when both detect inputs are low
  function automatic logic pcss_card_seated(input logic [1:0] cd_b);
    return cd_b == 2'b00;
  endfunction
endpackage

/* File: verilog/pcss_reset_ctl.sv */
// Card reset pin driver for one socket.
// Drives RESET only when card seated, powered and interface enabled.
`timescale 1ns/100ps
`default_nettype none
module pcss_reset_ctl
  import pcss_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic card_present,
  input  wire logic power_on,
  input  wire logic if_enable,
  input  wire logic reset_req,
  output logic      card_rst_o,
  output logic      card_rst_oe
);
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      card_rst_o  <= RESET_CARD_RST;
      card_rst_oe <= 1'b0;
    end else begin
      card_rst_oe <= card_present && power_on && if_enable;
      card_rst_o  <= reset_req;
    end
  end

  p_rst_hiz: assert property (@(posedge core_clk) disable iff (!rst_b)
    !(card_present && power_on && if_enable) |=> !card_rst_oe)
    else $error("card reset driven without seat, power and enable");
  a_rst_hiz: assert property (@(posedge core_clk) disable iff (!rst_b)
    card_rst_oe |-> $past(card_present) && $past(power_on) && $past(if_enable))
    else $error("card reset enable without cause");
  a_rst_lvl: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(reset_req) |=> card_rst_o)
    else $error("card reset did not rise on request");
endmodule
`default_nettype wire

/* File: verilog/pcss_socket.sv */
// One socket's access sequencer with pin drivers, plus two-socket top.
// Assumes a host-side request port; pins sampled on core_clk.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Memory mode: REG low selects attribute space
// - I/O mode: REG held low during accesses
// - ATA mode: REG always high
// - 26-bit address output per socket
// - 16-bit data bus, adapter drives writes
// - OE low during memory read
// - WE low during memory write
// - IORD low during I/O read
// - IOWR low during I/O write
// - Memory mode: WP input is write protect
// - I/O mode: IOIS16 sizes the access
// - Memory mode: RDY input is ready status
// - I/O mode: IREQ low is interrupt
// - WAIT low stretches the cycle
// - Card detect pins give card presence
// - CE1 even byte, CE2 odd, both word
// - 8-bit card: only CE1, A0 selects
// - RESET low normally, high resets card
// - RESET high-Z unless seated, powered, enabled
// - INPACK input ignored
// - Two sockets, fully separate pin sets
// - ATA mode switches pins to alternate use
module pcss_socket
  import pcss_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  // Socket configuration
  input  wire pcss_mode_t        mode,
  input  wire logic              card_8bit,
  input  wire logic              power_on,
  input  wire logic              if_enable,
  input  wire logic              card_reset_req,
  // Host request port
  input  wire logic              req_valid,
  input  wire pcss_op_t          req_op,
  input  wire logic              req_attr,
  input  wire logic              req_word,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  output logic                   rsp_err,
  // Status toward host
  output logic                   card_present,
  output logic                   write_protect,
  output logic                   card_ready,
  output logic                   card_irq,
  output logic                   ata_mode,
  // Card pins
  output logic [ADDR_W-1:0]      card_addr,
  input  wire logic [DATA_W-1:0] card_data_i,
  output logic [DATA_W-1:0]      card_data_o,
  output logic                   card_data_oe,
  output logic                   reg_b,
  output logic                   oe_b,
  output logic                   we_b,
  output logic                   iord_b,
  output logic                   iowr_b,
  output logic [1:0]             ce_b,
  input  wire logic              wp_iois16_b,
  input  wire logic              rdy_ireq_b,
  input  wire logic              wait_b,
  input  wire logic              inpack_b,
  input  wire logic [1:0]        cd_b,
  output logic                   card_rst_o,
  output logic                   card_rst_oe
);
  typedef enum logic [1:0] {PCSS_IDLE, PCSS_SETUP, PCSS_STROBE, PCSS_DONE} pcss_state_t;

  pcss_state_t state;
  pcss_op_t    op;
  logic [3:0]  cnt;
  logic        io_is16;
  logic        word_acc;
  logic        unused_inpack;

  // Input acknowledge plays no part here
  assign unused_inpack = inpack_b;

  // ==========================================================
  // Status inputs and card reset
  pcss_in_sync u_in (
    .core_clk      (core_clk),
    .rst_b         (rst_b),
    .mode          (mode),
    .cd_b          (cd_b),
    .wp_iois16_b   (wp_iois16_b),
    .rdy_ireq_b    (rdy_ireq_b),
    .card_present  (card_present),
    .write_protect (write_protect),
    .io_is16       (io_is16),
    .card_ready    (card_ready),
    .card_irq      (card_irq)
  );

  pcss_reset_ctl u_rst (
    .core_clk     (core_clk),
    .rst_b        (rst_b),
    .card_present (card_present),
    .power_on     (power_on),
    .if_enable    (if_enable),
    .reset_req    (card_reset_req),
    .card_rst_o   (card_rst_o),
    .card_rst_oe  (card_rst_oe)
  );

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ata_mode <= 1'b0;
    end else begin
      ata_mode <= (mode == PCSS_IF_ATA);
    end
  end

  // ==========================================================
  // Access sequencer
  // Requests are refused while no card is seated, so the pins stay idle.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state     <= PCSS_IDLE;
      op        <= PCSS_OP_MEM_RD;
      cnt       <= 4'h0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_err   <= 1'b0;
      rsp_rdata <= 16'h0000;
      word_acc  <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (state)
        PCSS_IDLE: begin
          req_ready <= 1'b1;
          if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            op        <= req_op;
            if (!card_present) begin
              rsp_valid <= 1'b1;
              rsp_err   <= 1'b1;
            end else begin
              rsp_err  <= 1'b0;
              word_acc <= req_word && !card_8bit;
              state    <= PCSS_SETUP;
            end
          end
        end
        PCSS_SETUP: begin
          // I/O width follows the card's size indication as sampled at the edge that drives this address out
          if (op == PCSS_OP_IO_RD || op == PCSS_OP_IO_WR) begin
            word_acc <= word_acc && io_is16;
          end
          cnt   <= STROBE_CNT;
          state <= PCSS_STROBE;
        end
        PCSS_STROBE: begin
          if (cnt > 4'h1) begin
            cnt <= cnt - 4'h1;
          end else if (wait_b) begin
            // Hold until the card releases WAIT
            rsp_rdata <= card_data_i;
            state     <= PCSS_DONE;
          end
        end
        PCSS_DONE: begin
          rsp_valid <= 1'b1;
          state     <= PCSS_IDLE;
        end
        default: state <= PCSS_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Pin drivers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      card_addr    <= '0;
      card_data_o  <= 16'h0000;
      card_data_oe <= 1'b0;
      reg_b        <= 1'b1;
      ce_b         <= 2'b11;
    end else if (state == PCSS_IDLE && req_valid && req_ready && card_present) begin
      card_addr    <= req_addr;
      card_data_o  <= req_wdata;
      card_data_oe <= (req_op == PCSS_OP_MEM_WR) || (req_op == PCSS_OP_IO_WR);
      case (mode)
        PCSS_IF_MEM: reg_b <= !req_attr;
        PCSS_IF_IO:  reg_b <= 1'b0;
        default:     reg_b <= 1'b1;
      endcase
      if (card_8bit) begin
        ce_b <= 2'b10;
      end else if (req_word) begin
        ce_b <= 2'b00;
      end else begin
        ce_b <= req_addr[0] ? 2'b01 : 2'b10;
      end
    end else if (state == PCSS_SETUP && word_acc && (op == PCSS_OP_IO_RD || op == PCSS_OP_IO_WR)
                 && !io_is16 && ce_b == 2'b00) begin
      ce_b <= card_addr[0] ? 2'b01 : 2'b10;
    end else if (state == PCSS_DONE) begin
      card_data_oe <= 1'b0;
      ce_b         <= 2'b11;
      reg_b        <= 1'b1;
    end
  end

  // Only one strobe can be low since each decodes a distinct op
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      oe_b   <= STROBE_IDLE;
      we_b   <= STROBE_IDLE;
      iord_b <= STROBE_IDLE;
      iowr_b <= STROBE_IDLE;
    end else begin
      oe_b   <= !((state == PCSS_SETUP || (state == PCSS_STROBE && !(cnt <= 4'h1 && wait_b)))
                  && op == PCSS_OP_MEM_RD);
      we_b   <= !((state == PCSS_SETUP || (state == PCSS_STROBE && !(cnt <= 4'h1 && wait_b)))
                  && op == PCSS_OP_MEM_WR);
      iord_b <= !((state == PCSS_SETUP || (state == PCSS_STROBE && !(cnt <= 4'h1 && wait_b)))
                  && op == PCSS_OP_IO_RD);
      iowr_b <= !((state == PCSS_SETUP || (state == PCSS_STROBE && !(cnt <= 4'h1 && wait_b)))
                  && op == PCSS_OP_IO_WR);
    end
  end

  // ==========================================================
  // Checks
  p_one_strobe: assert property (@(posedge core_clk) disable iff (!rst_b)
    $countones({!oe_b, !we_b, !iord_b, !iowr_b}) <= 1)
    else $error("more than one strobe active");
  a_one_strobe: assert property (@(posedge core_clk) disable iff (!rst_b)
    $countones({!oe_b, !we_b, !iord_b, !iowr_b}) <= 1)
    else $error("more than one strobe active");
  a_ata_reg: assert property (@(posedge core_clk) disable iff (!rst_b)
    (mode == PCSS_IF_ATA) [*2] |-> reg_b)
    else $error("reg select low in ATA mode");
  a_io_reg: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!iord_b || !iowr_b) && mode == PCSS_IF_IO |-> !reg_b)
    else $error("reg select high during I/O access");
  a_wait_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    state == PCSS_STROBE && cnt <= 4'h1 && !wait_b |=> state == PCSS_STROBE)
    else $error("cycle ended while card waits");
  a_wr_drive: assert property (@(posedge core_clk) disable iff (!rst_b)
    !we_b || !iowr_b |-> card_data_oe)
    else $error("write strobe without data drive");
  a_rd_nodrive: assert property (@(posedge core_clk) disable iff (!rst_b)
    !oe_b || !iord_b |-> !card_data_oe)
    else $error("data driven during read");
  a_ce8: assert property (@(posedge core_clk) disable iff (!rst_b)
    card_8bit && $stable(card_8bit) && ce_b != 2'b11 |-> ce_b == 2'b10)
    else $error("CE2 used on 8-bit card");
  a_absent: assert property (@(posedge core_clk) disable iff (!rst_b)
    state == PCSS_IDLE && req_valid && req_ready && !card_present |=> rsp_valid && rsp_err)
    else $error("absent card not refused");
endmodule

// ==========================================================
// Two independent sockets
module pcss_top
  import pcss_pkg::*;
(
  input  wire logic                       core_clk,
  input  wire logic                       rst_b,
  input  wire pcss_mode_t [NUM_SOCK-1:0]  mode,
  input  wire logic [NUM_SOCK-1:0]        card_8bit,
  input  wire logic [NUM_SOCK-1:0]        power_on,
  input  wire logic [NUM_SOCK-1:0]        if_enable,
  input  wire logic [NUM_SOCK-1:0]        card_reset_req,
  input  wire logic [NUM_SOCK-1:0]        req_valid,
  input  wire pcss_op_t [NUM_SOCK-1:0]    req_op,
  input  wire logic [NUM_SOCK-1:0]        req_attr,
  input  wire logic [NUM_SOCK-1:0]        req_word,
  input  wire logic [NUM_SOCK-1:0][ADDR_W-1:0] req_addr,
  input  wire logic [NUM_SOCK-1:0][DATA_W-1:0] req_wdata,
  output logic [NUM_SOCK-1:0]             req_ready,
  output logic [NUM_SOCK-1:0]             rsp_valid,
  output logic [NUM_SOCK-1:0][DATA_W-1:0] rsp_rdata,
  output logic [NUM_SOCK-1:0]             rsp_err,
  output logic [NUM_SOCK-1:0]             card_present,
  output logic [NUM_SOCK-1:0]             write_protect,
  output logic [NUM_SOCK-1:0]             card_ready,
  output logic [NUM_SOCK-1:0]             card_irq,
  output logic [NUM_SOCK-1:0]             ata_mode,
  output logic [NUM_SOCK-1:0][ADDR_W-1:0] card_addr,
  input  wire logic [NUM_SOCK-1:0][DATA_W-1:0] card_data_i,
  output logic [NUM_SOCK-1:0][DATA_W-1:0] card_data_o,
  output logic [NUM_SOCK-1:0]             card_data_oe,
  output logic [NUM_SOCK-1:0]             reg_b,
  output logic [NUM_SOCK-1:0]             oe_b,
  output logic [NUM_SOCK-1:0]             we_b,
  output logic [NUM_SOCK-1:0]             iord_b,
  output logic [NUM_SOCK-1:0]             iowr_b,
  output logic [NUM_SOCK-1:0][1:0]        ce_b,
  input  wire logic [NUM_SOCK-1:0]        wp_iois16_b,
  input  wire logic [NUM_SOCK-1:0]        rdy_ireq_b,
  input  wire logic [NUM_SOCK-1:0]        wait_b,
  input  wire logic [NUM_SOCK-1:0]        inpack_b,
  input  wire logic [NUM_SOCK-1:0][1:0]   cd_b,
  output logic [NUM_SOCK-1:0]             card_rst_o,
  output logic [NUM_SOCK-1:0]             card_rst_oe
);
  // Each socket gets its own sequencer and pins
  for (genvar s = 0; s < NUM_SOCK; s++) begin : g_sock
    pcss_socket u_sock (
      .core_clk       (core_clk),
      .rst_b          (rst_b),
      .mode           (mode[s]),
      .card_8bit      (card_8bit[s]),
      .power_on       (power_on[s]),
      .if_enable      (if_enable[s]),
      .card_reset_req (card_reset_req[s]),
      .req_valid      (req_valid[s]),
      .req_op         (req_op[s]),
      .req_attr       (req_attr[s]),
      .req_word       (req_word[s]),
      .req_addr       (req_addr[s]),
      .req_wdata      (req_wdata[s]),
      .req_ready      (req_ready[s]),
      .rsp_valid      (rsp_valid[s]),
      .rsp_rdata      (rsp_rdata[s]),
      .rsp_err        (rsp_err[s]),
      .card_present   (card_present[s]),
      .write_protect  (write_protect[s]),
      .card_ready     (card_ready[s]),
      .card_irq       (card_irq[s]),
      .ata_mode       (ata_mode[s]),
      .card_addr      (card_addr[s]),
      .card_data_i    (card_data_i[s]),
      .card_data_o    (card_data_o[s]),
      .card_data_oe   (card_data_oe[s]),
      .reg_b          (reg_b[s]),
      .oe_b           (oe_b[s]),
      .we_b           (we_b[s]),
      .iord_b         (iord_b[s]),
      .iowr_b         (iowr_b[s]),
      .ce_b           (ce_b[s]),
      .wp_iois16_b    (wp_iois16_b[s]),
      .rdy_ireq_b     (rdy_ireq_b[s]),
      .wait_b         (wait_b[s]),
      .inpack_b       (inpack_b[s]),
      .cd_b           (cd_b[s]),
      .card_rst_o     (card_rst_o[s]),
      .card_rst_oe    (card_rst_oe[s])
    );
  end
endmodule
`default_nettype wire
